// ===== hdl/hbc_pkg.sv
// Purpose: constants and types for the h-bridge control block
// Assumes: 125 MHz clock
// Notes: register offsets are byte addresses on apb
package hbc_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned CLK_MHZ = 125;
  // dead time between opposite switches of one leg
  localparam int unsigned DEAD_NS = 500;
  localparam logic [6:0] DEAD_CYC = 7'((DEAD_NS * CLK_MHZ + 999) / 1000);
  // internal chopping oscillator, typical frequency
  localparam int unsigned CHOP_HZ = 46000;
  localparam logic [11:0] CHOP_CYC = 12'(CLK_HZ / CHOP_HZ);
  // enable high time before a short can be seen
  localparam int unsigned SC_QUAL_US = 16;
  localparam logic [11:0] SC_QUAL_CYC = 12'(SC_QUAL_US * CLK_MHZ);
  // apb map
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;
  // cause and event bit positions
  localparam int unsigned EV_SHORT = 0;
  localparam int unsigned EV_OVERCUR = 1;
  localparam int unsigned EV_OVERHEAT = 2;
  localparam int unsigned EV_UNDERVOLT = 3;
  localparam int unsigned EV_CHOP = 4;
  // status register fields
  localparam int unsigned ST_FAULT_POS = 0;
  localparam int unsigned ST_CAUSE_POS = 1;
  localparam int unsigned ST_MODE_POS = 8;
  // leg word layout
  localparam int unsigned LEG_HS = 9;
  localparam int unsigned LEG_LS = 8;
  localparam int unsigned LEG_LAST = 7;

  typedef enum logic [2:0] {
    HBC_STOP,
    HBC_FWD,
    HBC_REV,
    HBC_BRAKE_HI,
    HBC_BRAKE_LO,
    HBC_FAULT
  } hbc_mode_e;

  typedef struct packed {
    logic [9:0] leg_a;
    logic [9:0] leg_b;
    logic [11:0] chop_cnt;
    logic chop_off;
    logic [11:0] qual_cnt;
    logic [3:0] cause;
    logic [4:0] irq_stat;
    logic [4:0] irq_mask;
    logic [31:0] prdata;
    logic pslverr;
    hbc_mode_e mode;
  } hbc_state_s;
endpackage : hbc_pkg

// ===== hdl/hbc_bridge.sv
// Purpose: h-bridge switch control with fault latch and apb registers
// Assumes: all inputs synchronous to clk; resetn is the supply power-on reset
// Notes: legs are a (high a, low a) and b (high b, low b)
`timescale 1ns/1ps
`default_nettype none
module hbc_bridge
  import hbc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic direction_input_a,
  input wire logic direction_input_b,
  input wire logic enable,
  input wire logic supply_low,
  input wire logic short_detect,
  input wire logic overcurrent_detect,
  input wire logic overheat_detect,
  input wire logic current_limit,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic high_side_switch_a,
  output logic high_side_switch_b,
  output logic low_side_switch_a,
  output logic low_side_switch_b,
  output logic fault_n,
  output logic irq
);
  import hbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // one leg: break-before-make with dead time
  function automatic logic [9:0] leg_step(
    input logic hs_req,
    input logic ls_req,
    input logic [9:0] leg
  );
    logic hs;
    logic ls;
    logic last_hs;
    logic [6:0] cnt;
    logic n_hs;
    logic n_ls;
    logic n_last;
    logic [6:0] n_cnt;
    hs = leg[LEG_HS];
    ls = leg[LEG_LS];
    last_hs = leg[LEG_LAST];
    cnt = leg[6:0];
    n_hs = hs_req & ~ls & ((cnt == 7'h00) | last_hs);
    n_ls = ls_req & ~hs & ((cnt == 7'h00) | ~last_hs);
    if ((hs & ~n_hs) | (ls & ~n_ls))
      n_cnt = DEAD_CYC;
    else if (cnt != 7'h00)
      n_cnt = cnt - 7'h01;
    else
      n_cnt = cnt;
    if (n_hs)
      n_last = 1'b1;
    else if (n_ls)
      n_last = 1'b0;
    else
      n_last = last_hs;
    return {n_hs, n_ls, n_last, n_cnt};
  endfunction : leg_step

  ////////////////////////////////////////////////////////////////////////////
  // state
  hbc_state_s st_r;
  hbc_state_s st_nxt;

  always_comb
  begin
    logic faulted;
    logic [3:0] trip;
    logic [4:0] ev;
    logic rotating;
    logic hs_a_req;
    logic hs_b_req;
    logic ls_a_req;
    logic ls_b_req;
    logic acc;
    logic setup;
    logic [31:0] rd;
    logic rd_ok;
    faulted = 1'b0;
    trip = 4'h0;
    ev = 5'h00;
    rotating = 1'b0;
    hs_a_req = 1'b0;
    hs_b_req = 1'b0;
    ls_a_req = 1'b0;
    ls_b_req = 1'b0;
    acc = 1'b0;
    setup = 1'b0;
    rd = 32'h0000_0000;
    rd_ok = 1'b0;
    st_nxt = st_r;

    // enable high-time qualifier for short detection
    if (!enable)
      st_nxt.qual_cnt = 12'h000;
    else if (st_r.qual_cnt != SC_QUAL_CYC)
      st_nxt.qual_cnt = st_r.qual_cnt + 12'h001;

    // detectors, latched until power-on reset
    rotating = enable & (direction_input_a ^ direction_input_b);
    trip[EV_SHORT] = short_detect & (st_r.qual_cnt == SC_QUAL_CYC);
    trip[EV_OVERCUR] = overcurrent_detect;
    trip[EV_OVERHEAT] = overheat_detect;
    trip[EV_UNDERVOLT] = supply_low & rotating;
    st_nxt.cause = st_r.cause | trip;
    faulted = |st_nxt.cause;

    // internal chopping oscillator
    if (st_r.chop_cnt == CHOP_CYC - 12'h001)
    begin
      st_nxt.chop_cnt = 12'h000;
      st_nxt.chop_off = 1'b0;
    end
    else
    begin
      st_nxt.chop_cnt = st_r.chop_cnt + 12'h001;
      if (current_limit)
        st_nxt.chop_off = 1'b1;
    end

    // switch requests from the input pins
    hs_a_req = ~direction_input_b;
    hs_b_req = ~direction_input_a;
    ls_a_req = direction_input_b & enable & ~st_nxt.chop_off;
    ls_b_req = direction_input_a & enable & ~st_nxt.chop_off;
    if (faulted)
    begin
      hs_a_req = 1'b0;
      hs_b_req = 1'b0;
      ls_a_req = 1'b0;
      ls_b_req = 1'b0;
    end
    st_nxt.leg_a = leg_step(hs_a_req, ls_a_req, st_r.leg_a);
    st_nxt.leg_b = leg_step(hs_b_req, ls_b_req, st_r.leg_b);

    // reported operating mode
    if (faulted)
      st_nxt.mode = HBC_FAULT;
    else if (!direction_input_a && !direction_input_b)
      st_nxt.mode = HBC_BRAKE_HI;
    else if (!enable)
      st_nxt.mode = HBC_STOP;
    else if (direction_input_a && direction_input_b)
      st_nxt.mode = HBC_BRAKE_LO;
    else if (direction_input_a)
      st_nxt.mode = HBC_FWD;
    else
      st_nxt.mode = HBC_REV;

    // interrupt events
    ev[3:0] = trip & ~st_r.cause;
    ev[EV_CHOP] = st_nxt.chop_off & ~st_r.chop_off;

    // apb: data captured in setup, write and read-clear in access
    setup = psel & ~penable;
    acc = psel & penable;
    case (paddr)
      ADDR_STATUS:
      begin
        rd[ST_FAULT_POS] = |st_r.cause;
        rd[ST_CAUSE_POS +: 4] = st_r.cause;
        rd[ST_MODE_POS +: 3] = st_r.mode;
        rd_ok = 1'b1;
      end
      ADDR_IRQ_STAT:
      begin
        rd[4:0] = st_r.irq_stat | ev; // setup-cycle event is not lost
        rd_ok = 1'b1;
      end
      ADDR_IRQ_MASK:
      begin
        rd[4:0] = st_r.irq_mask;
        rd_ok = 1'b1;
      end
      default:
      begin
        rd = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
    if (setup)
    begin
      st_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
      st_nxt.pslverr = ~rd_ok;
    end
    if (acc && pwrite && paddr == ADDR_IRQ_MASK)
      st_nxt.irq_mask = pwdata[4:0];
    if (acc && !pwrite && paddr == ADDR_IRQ_STAT)
      st_nxt.irq_stat = ev; // set wins over read-clear
    else
      st_nxt.irq_stat = st_r.irq_stat | ev;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '{leg_a: 10'h000, leg_b: 10'h000, chop_cnt: 12'h000,
                chop_off: 1'b0, qual_cnt: 12'h000, cause: 4'h0,
                irq_stat: 5'h00, irq_mask: IRQ_MASK_RST,
                prdata: 32'h0000_0000, pslverr: 1'b0, mode: HBC_STOP};
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign high_side_switch_a = st_r.leg_a[LEG_HS];
  assign low_side_switch_a = st_r.leg_a[LEG_LS];
  assign high_side_switch_b = st_r.leg_b[LEG_HS];
  assign low_side_switch_b = st_r.leg_b[LEG_LS];
  assign fault_n = ~(|st_r.cause);
  assign irq = |(st_r.irq_stat & st_r.irq_mask);
  assign prdata = st_r.prdata;
  assign pslverr = st_r.pslverr;
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_stop_unpowered;
    @(posedge clk) disable iff (!resetn)
    (ce && !enable) |=> (!low_side_switch_a && !low_side_switch_b);
  endproperty
  a_stop_unpowered: assert property (p_stop_unpowered)
    else $error("low side on with enable low");

  property p_leg_b_map;
    @(posedge clk) disable iff (!resetn)
    $rose(high_side_switch_b) |-> $past(!direction_input_a);
  endproperty
  a_leg_b_map: assert property (p_leg_b_map)
    else $error("high b turned on with input a high");

  property p_dead_time;
    @(posedge clk) disable iff (!resetn)
    $fell(low_side_switch_a) |-> !high_side_switch_a [*8];
  endproperty
  a_dead_time: assert property (p_dead_time)
    else $error("high a on inside dead time");

  property p_brake_hi;
    @(posedge clk) disable iff (!resetn)
    $rose(high_side_switch_a) |-> $past(!direction_input_b);
  endproperty
  a_brake_hi: assert property (p_brake_hi)
    else $error("high a turned on with input b high");

  property p_brake_lo;
    @(posedge clk) disable iff (!resetn)
    $rose(low_side_switch_a) |-> $past(enable && direction_input_b);
  endproperty
  a_brake_lo: assert property (p_brake_lo)
    else $error("low a on without enable and input b");

  property p_fault_sticky;
    @(posedge clk) disable iff (!resetn)
    !fault_n |=> (!fault_n && !high_side_switch_a && !high_side_switch_b
      && !low_side_switch_a && !low_side_switch_b);
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault released or switch on while faulted");

  property p_overheat_trip;
    @(posedge clk) disable iff (!resetn)
    (ce && overheat_detect) |=> !fault_n;
  endproperty
  a_overheat_trip: assert property (p_overheat_trip)
    else $error("overheat did not raise fault");

  property p_undervolt;
    @(posedge clk) disable iff (!resetn)
    (ce && supply_low && enable && (direction_input_a != direction_input_b))
      |=> !fault_n;
  endproperty
  a_undervolt: assert property (p_undervolt)
    else $error("low supply while rotating did not fault");

  property p_chop_low_only;
    @(posedge clk) disable iff (!resetn)
    st_r.chop_off |-> (!low_side_switch_a && !low_side_switch_b);
  endproperty
  a_chop_low_only: assert property (p_chop_low_only)
    else $error("low side on during chop-off");
endmodule : hbc_bridge
`default_nettype wire

// ===== verif/hbc_ctrl_model.sv
// Purpose: controller model that drives the direction and enable pins
// Assumes: bench commands arrive on clk; one clock domain
// Notes: idles the bridge once fault_n is low unless told to defy
`timescale 1ns/1ps
`default_nettype none
module hbc_ctrl_model
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_a,
  input wire logic cmd_b,
  input wire logic cmd_en,
  input wire logic ramp,
  input wire logic defy,
  input wire logic fault_n,
  output logic dir_a,
  output logic dir_b,
  output logic en
);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dir_a <= 1'b1;
      dir_b <= 1'b1;
      en <= 1'b0;
    end
    else if (!fault_n && !defy)
    begin
      dir_a <= 1'b1;
      dir_b <= 1'b1;
      en <= 1'b0;
    end
    else
    begin
      dir_a <= cmd_a;
      dir_b <= cmd_b;
      en <= cmd_en && !ramp;
    end
  end
endmodule : hbc_ctrl_model
`default_nettype wire

// ===== verif/testbench.sv
// Purpose: self-checking bench for the h-bridge control block
// Assumes: 125 MHz clock; pready answers in the access cycle
// Notes: switch word is {high a, high b, low a, low b}
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hbc_pkg::*;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, lim = 0;
  logic ca = 1, cb = 1, cen = 0, ramp = 0, defy = 0, da, db, en;
  logic ce = 1;
  logic [3:0] det = 4'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, hsa, hsb, lsa, lsb, fault_n, irq, e;
  int n_errors = 0, checked = 0;
  always #4 clk = ~clk;
  hbc_ctrl_model hbc_ctrl_model_i (.clk(clk), .resetn(resetn), .cmd_a(ca),
    .cmd_b(cb), .cmd_en(cen), .ramp(ramp), .defy(defy), .fault_n(fault_n),
    .dir_a(da), .dir_b(db), .en(en));
  hbc_bridge hbc_bridge_i (.clk(clk), .resetn(resetn), .ce(ce),
    .direction_input_a(da), .direction_input_b(db), .enable(en),
    .supply_low(det[3]), .short_detect(det[0]),
    .overcurrent_detect(det[1]), .overheat_detect(det[2]),
    .current_limit(lim), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .high_side_switch_a(hsa), .high_side_switch_b(hsb),
    .low_side_switch_a(lsa), .low_side_switch_b(lsb), .fault_n(fault_n),
    .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task sw(input logic [3:0] exp);
    chk({28'h0, hsa, hsb, lsa, lsb}, {28'h0, exp});
  endtask : sw
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task drive(input logic a, input logic b, input logic n, input int c);
    @(posedge clk);
    ca <= a;
    cb <= b;
    cen <= n;
    repeat (c) @(posedge clk);
    #1;
  endtask : drive
  task do_reset;
    @(posedge clk);
    resetn <= 1'b0;
    defy <= 1'b0;
    det <= 4'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (30000) @(posedge clk);
    n_errors++;
    finish_test();
  end
  initial
  begin
    do_reset();
    #1;
    sw(4'h0);
    chk({30'h0, fault_n, irq}, 32'h2);
    for (int i = 0; i < 8; i++)
    begin
      drive(i[2], i[1], i[0], 80);
      sw({!i[1], !i[2], i[1] & i[0], i[2] & i[0]});
    end
    drive(1, 0, 1, 80);
    drive(0, 1, 1, 32);
    sw(4'h0);
    repeat (50) @(posedge clk);
    #1;
    sw(4'h6);
    drive(1, 0, 1, 80);
    drive(1, 0, 0, 2400);
    sw(4'h8);
    drive(1, 0, 1, 130);
    sw(4'h9);
    apb(0, ADDR_IRQ_MASK, 0);
    chk(q, 32'h0);
    @(posedge clk);
    lim <= 1'b1;
    @(posedge clk);
    lim <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    sw(4'h8);
    chk({31'h0, irq}, 32'h0);
    apb(1, ADDR_IRQ_MASK, 32'h10);
    apb(0, ADDR_IRQ_MASK, 0);
    chk(q, 32'h10);
    #1;
    chk({31'h0, irq}, 32'h1);
    apb(0, ADDR_IRQ_STAT, 0);
    chk(q, 32'h10);
    #1;
    chk({31'h0, irq}, 32'h0);
    apb(0, 8'h0C, 0);
    chk({q[30:0], e}, 32'h1);
    repeat (2800) @(posedge clk);
    #1;
    sw(4'h9);
    @(posedge clk);
    ramp <= 1'b1;
    repeat (2) @(posedge clk);
    det[3] <= 1'b1;
    repeat (10) @(posedge clk);
    det[3] <= 1'b0;
    #1;
    chk({31'h0, fault_n}, 32'h1);
    sw(4'h8);
    @(posedge clk);
    ramp <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      do_reset();
      drive(1, 0, 1, 100);
      @(posedge clk);
      if (k == 0)
      begin
        det[0] <= 1'b1;
        @(posedge clk);
        det[0] <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({31'h0, fault_n}, 32'h1);
        repeat (2000) @(posedge clk);
      end
      det[k] <= 1'b1;
      repeat (3) @(posedge clk);
      det[k] <= 1'b0;
      #1;
      chk({31'h0, fault_n}, 32'h0);
      sw(4'h0);
      apb(0, ADDR_STATUS, 0);
      chk(q, 32'h501 | (32'h2 << k));
      defy <= 1'b1;
      drive(0, 0, 1, 80);
      sw(4'h0);
      chk({31'h0, fault_n}, 32'h0);
    end
    do_reset();
    drive(0, 0, 0, 80);
    sw(4'hC);
    @(posedge clk);
    ce <= 1'b0;
    drive(1, 0, 1, 80);
    sw(4'hC);
    @(posedge clk);
    ce <= 1'b1;
    drive(1, 0, 1, 80);
    sw(4'h9);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
